// *** src/srf_link_if.sv ***
// Frame link between the bit engine and the frame processor.
// Assumes both ends run on ref_clk.
interface srf_link_if;
    logic [srf_pkg::FRAME_BITS-1:0] tx_frame;
    logic [srf_pkg::FRAME_BITS-1:0] rx_frame;
    logic frame_start;
    logic frame_end;
    logic frame_ok;
    modport engine (input tx_frame, output rx_frame, output frame_start, output frame_end,
        output frame_ok);
    modport framer (output tx_frame, input rx_frame, input frame_start, input frame_end,
        input frame_ok);
endinterface : srf_link_if

// *** src/srf_pkg.sv ***
// Constants of the serial register frame port: framing, words, codes, timing.
// Assumes a single 10 MHz clock; all serial pins arrive synchronous to it.
package srf_pkg;
    localparam int FRAME_BYTES = 14;
    localparam int BYTE_BITS = 8;
    localparam int FRAME_BITS = FRAME_BYTES * BYTE_BITS;
    localparam int WORD_BITS = 16;
    localparam logic [7:0] FRAME_BITS_CNT = 8'h70;
    localparam logic [7:0] BIT_CNT_MAX = 8'hFF;
    localparam logic [15:0] FLAG_WRITE = 16'h0001;
    localparam logic [15:0] FLAG_READ = 16'h0000;
    localparam logic [15:0] ADDR_FAIL = 16'h0000;
    localparam logic [31:0] FAIL_PATTERN = 32'h7CF0BDC2;
    // Local read-pointer registers and their power-up targets (X, Y read-back)
    localparam logic [15:0] PTR0_ADDR = 16'h0F00;
    localparam logic [15:0] PTR1_ADDR = 16'h0F01;
    localparam logic [15:0] PTR0_RESET = 16'h5001;
    localparam logic [15:0] PTR1_RESET = 16'h5101;
    localparam logic [15:0] PREV_RD_RESET = 16'h0000;
    // Timing
    localparam int CLK_PERIOD_NS = 100;
    localparam int SCLK_MAX_HZ = 4000000;
    localparam int UPDATE_PERIOD_NS = 100000;
    localparam int UPDATE_CYC = UPDATE_PERIOD_NS / CLK_PERIOD_NS;
    localparam logic [9:0] UPDATE_LAST = 10'(UPDATE_CYC - 1);
    localparam logic [4:0] ACC_TIMEOUT_LAST = 5'h0F;
endpackage : srf_pkg

// *** src/srf_port.sv ***
// Serial register frame port: decodes frames, runs register accesses, builds
// the answer sent in the next frame and drives the frame pending flag.
// Assumes an attached register store answering reg_req with a one-cycle reg_ack.
module srf_port (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // Serial pins
    input wire logic spi_sclk,
    input wire logic spi_nss_n,
    input wire logic spi_mosi,
    output logic spi_miso,
    output logic spi_miso_oe,
    output logic frame_pending_flag,
    // Register store access
    output logic reg_req,
    output logic reg_we,
    output logic [15:0] reg_addr,
    output logic [31:0] reg_wdata,
    input wire logic reg_ack,
    input wire logic reg_fail,
    input wire logic [31:0] reg_rdata
);
    typedef enum logic [2:0] {
        SRF_IDLE, SRF_WAIT_TICK, SRF_WR0, SRF_WR1, SRF_RDQ, SRF_RP0, SRF_RP1, SRF_LOAD
    } srf_state_t;

    srf_state_t state_reg;
    srf_state_t state_next;
    logic [9:0] tick_cnt_reg;
    logic tick;
    logic [4:0] wait_cnt_reg;
    logic acc_done;
    logic acc_ok;
    logic local_ptr;
    logic [15:0] cmd_flag_reg;
    logic [15:0] cmd_a1_reg;
    logic [15:0] cmd_a2_reg;
    logic [31:0] cmd_d1_reg;
    logic [31:0] cmd_d2_reg;
    logic [15:0] ptr0_reg;
    logic [15:0] ptr1_reg;
    logic [15:0] prev_rd_reg;
    logic [15:0] res_a1_reg;
    logic [15:0] res_a2_reg;
    logic [31:0] res_rq_reg;
    logic [31:0] res_p0_reg;
    logic [31:0] res_p1_reg;
    logic [1:0] wr_cnt_reg;
    srf_link_if link ();

    ////////////////////////////////////////////////////////////////////////////
    // Bit engine; the port needs no enabling step and is live from reset
    srf_shift u_shift (
        .ref_clk(ref_clk),
        .rstn(rstn),
        .spi_sclk(spi_sclk),
        .spi_nss_n(spi_nss_n),
        .spi_mosi(spi_mosi),
        .spi_miso(spi_miso),
        .spi_miso_oe(spi_miso_oe),
        .link(link)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Register update tick at 10 kHz
    assign tick = (tick_cnt_reg == srf_pkg::UPDATE_LAST);

    always_ff @(posedge ref_clk)
    begin
        if (!rstn || tick)
        begin
            tick_cnt_reg <= 10'h000;
        end
        else
        begin
            tick_cnt_reg <= tick_cnt_reg + 10'h001;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Access completion; pointer registers live here, a silent store times out
    assign local_ptr = (reg_addr == srf_pkg::PTR0_ADDR) || (reg_addr == srf_pkg::PTR1_ADDR);
    assign reg_req = (state_reg inside {SRF_WR0, SRF_WR1, SRF_RDQ, SRF_RP0, SRF_RP1})
        && !(reg_we && local_ptr);
    assign acc_done = (reg_we && local_ptr) || reg_ack
        || (wait_cnt_reg == srf_pkg::ACC_TIMEOUT_LAST);
    assign acc_ok = (reg_we && local_ptr) || (reg_ack && !reg_fail);

    always_ff @(posedge ref_clk)
    begin
        if (!rstn || acc_done || !reg_req)
        begin
            wait_cnt_reg <= 5'h00;
        end
        else
        begin
            wait_cnt_reg <= wait_cnt_reg + 5'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Sequence: two writes or one request read, then two pointer reads
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            SRF_IDLE:
            begin
                if (link.frame_ok)
                begin
                    state_next = SRF_WAIT_TICK;
                end
            end
            SRF_WAIT_TICK:
            begin
                if (tick)
                begin
                    state_next = (cmd_flag_reg == srf_pkg::FLAG_WRITE) ? SRF_WR0 : SRF_RDQ;
                end
            end
            SRF_WR0:
            begin
                if (acc_done)
                begin
                    state_next = SRF_WR1;
                end
            end
            SRF_WR1:
            begin
                if (acc_done)
                begin
                    state_next = SRF_RP0;
                end
            end
            SRF_RDQ:
            begin
                if (acc_done)
                begin
                    state_next = SRF_RP0;
                end
            end
            SRF_RP0:
            begin
                if (acc_done)
                begin
                    state_next = SRF_RP1;
                end
            end
            SRF_RP1:
            begin
                if (acc_done)
                begin
                    state_next = SRF_LOAD;
                end
            end
            SRF_LOAD:
            begin
                state_next = SRF_IDLE;
            end
            default:
            begin
                state_next = SRF_IDLE;
            end
        endcase
    end

    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            state_reg <= SRF_IDLE;
        end
        else
        begin
            state_reg <= state_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Access address and data staged for the state being entered
    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            reg_we <= 1'b0;
            reg_addr <= 16'h0000;
            reg_wdata <= 32'h00000000;
        end
        else if (state_next != state_reg)
        begin
            reg_we <= (state_next == SRF_WR0) || (state_next == SRF_WR1);
            reg_wdata <= (state_next == SRF_WR1) ? cmd_d2_reg : cmd_d1_reg;
            case (state_next)
                SRF_WR0: reg_addr <= cmd_a1_reg;
                SRF_WR1: reg_addr <= cmd_a2_reg;
                SRF_RDQ: reg_addr <= prev_rd_reg;
                SRF_RP0: reg_addr <= ptr0_reg;
                SRF_RP1: reg_addr <= ptr1_reg;
                default: reg_addr <= 16'h0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Request capture: seven words, 32-bit values upper half first
    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            cmd_flag_reg <= srf_pkg::FLAG_READ;
            cmd_a1_reg <= 16'h0000;
            cmd_a2_reg <= 16'h0000;
            cmd_d1_reg <= 32'h00000000;
            cmd_d2_reg <= 32'h00000000;
        end
        else if (link.frame_ok && state_reg == SRF_IDLE)
        begin
            cmd_flag_reg <= link.rx_frame[111:96];
            cmd_a1_reg <= link.rx_frame[95:80];
            cmd_a2_reg <= link.rx_frame[79:64];
            cmd_d1_reg <= link.rx_frame[63:32];
            cmd_d2_reg <= link.rx_frame[31:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pointer registers, default to X and Y read-back; request address memory
    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            ptr0_reg <= srf_pkg::PTR0_RESET;
            ptr1_reg <= srf_pkg::PTR1_RESET;
            prev_rd_reg <= srf_pkg::PREV_RD_RESET;
        end
        else
        begin
            if (reg_we && local_ptr && reg_addr == srf_pkg::PTR0_ADDR)
            begin
                ptr0_reg <= reg_wdata[15:0];
            end
            if (reg_we && local_ptr && reg_addr == srf_pkg::PTR1_ADDR)
            begin
                ptr1_reg <= reg_wdata[15:0];
            end
            if (state_reg == SRF_RDQ && acc_done)
            begin
                prev_rd_reg <= cmd_a1_reg;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Access results: zero address on failed write, fail pattern on failed read
    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            res_a1_reg <= 16'h0000;
            res_a2_reg <= 16'h0000;
            res_rq_reg <= srf_pkg::FAIL_PATTERN;
            res_p0_reg <= srf_pkg::FAIL_PATTERN;
            res_p1_reg <= srf_pkg::FAIL_PATTERN;
            wr_cnt_reg <= 2'b00;
        end
        else
        begin
            if (state_reg == SRF_WAIT_TICK)
            begin
                wr_cnt_reg <= 2'b00;
            end
            else if (reg_we && acc_done && state_reg inside {SRF_WR0, SRF_WR1})
            begin
                wr_cnt_reg <= wr_cnt_reg + 2'b01;
            end
            if (acc_done)
            begin
                case (state_reg)
                    SRF_WR0: res_a1_reg <= acc_ok ? cmd_a1_reg : srf_pkg::ADDR_FAIL;
                    SRF_WR1: res_a2_reg <= acc_ok ? cmd_a2_reg : srf_pkg::ADDR_FAIL;
                    SRF_RDQ: res_rq_reg <= acc_ok ? reg_rdata : srf_pkg::FAIL_PATTERN;
                    SRF_RP0: res_p0_reg <= acc_ok ? reg_rdata : srf_pkg::FAIL_PATTERN;
                    SRF_RP1: res_p1_reg <= acc_ok ? reg_rdata : srf_pkg::FAIL_PATTERN;
                    default: res_p1_reg <= res_p1_reg;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Answer frame, sent during the next frame; last eight bytes are read-back
    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            link.tx_frame <= {srf_pkg::FLAG_READ, srf_pkg::FAIL_PATTERN,
                srf_pkg::FAIL_PATTERN, srf_pkg::FAIL_PATTERN};
        end
        else if (state_reg == SRF_LOAD)
        begin
            link.tx_frame[111:96] <= cmd_flag_reg;
            link.tx_frame[95:64] <= (cmd_flag_reg == srf_pkg::FLAG_WRITE) ?
                {res_a1_reg, res_a2_reg} : res_rq_reg;
            link.tx_frame[63:0] <= {res_p0_reg, res_p1_reg};
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Pending flag: up at frame start, down once the answer is loaded or the
    // frame was malformed; a start in the same cycle wins
    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            frame_pending_flag <= 1'b0;
        end
        else if (link.frame_start)
        begin
            frame_pending_flag <= 1'b1;
        end
        else if (state_reg == SRF_LOAD || (link.frame_end && !link.frame_ok))
        begin
            frame_pending_flag <= 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    property p_pend_rise;
        @(posedge ref_clk) disable iff (!rstn)
        link.frame_start |=> frame_pending_flag;
    endproperty
    a_pend_rise: assert property (p_pend_rise) else $error("pending not raised");

    property p_pend_fall;
        @(posedge ref_clk) disable iff (!rstn)
        $fell(frame_pending_flag) |-> $past(state_reg) == SRF_LOAD
            || ($past(link.frame_end) && !$past(link.frame_ok));
    endproperty
    a_pend_fall: assert property (p_pend_fall) else $error("pending dropped early");

    property p_tick_start;
        @(posedge ref_clk) disable iff (!rstn)
        (state_reg == SRF_WAIT_TICK && state_next != SRF_WAIT_TICK) |-> tick;
    endproperty
    a_tick_start: assert property (p_tick_start) else $error("processing off tick");

    property p_two_writes;
        @(posedge ref_clk) disable iff (!rstn)
        state_reg == SRF_LOAD |-> wr_cnt_reg <= 2'b10;
    endproperty
    a_two_writes: assert property (p_two_writes) else $error("more than two writes");

    property p_write_echo;
        @(posedge ref_clk) disable iff (!rstn)
        (state_reg == SRF_LOAD && cmd_flag_reg == srf_pkg::FLAG_WRITE) |=>
            link.tx_frame[111:96] == 16'h0001 && link.tx_frame[95:80] == $past(res_a1_reg);
    endproperty
    a_write_echo: assert property (p_write_echo) else $error("write echo wrong");

    property p_fail_pattern;
        @(posedge ref_clk) disable iff (!rstn)
        (state_reg == SRF_RP1 && acc_done && !acc_ok) ##1 (state_reg == SRF_LOAD) |=>
            link.tx_frame[31:0] == 32'h7CF0BDC2;
    endproperty
    a_fail_pattern: assert property (p_fail_pattern) else $error("fail pattern missing");

    property p_ptr_default;
        @(posedge ref_clk)
        $past(!rstn) |-> ptr0_reg == 16'h5001 && ptr1_reg == 16'h5101;
    endproperty
    a_ptr_default: assert property (p_ptr_default) else $error("pointer default wrong");
endmodule // srf_port

// *** src/srf_shift.sv ***
// Bit engine of the serial port: edge detection, shifting, frame length check.
// Assumes pins synchronous to ref_clk and a serial clock of at most 4 MHz.
module srf_shift (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rstn,
    // Serial pins
    input wire logic spi_sclk,
    input wire logic spi_nss_n,
    input wire logic spi_mosi,
    output logic spi_miso,
    output logic spi_miso_oe,
    // Frame link
    srf_link_if.engine link
);
    logic sclk_q_reg;
    logic nss_q_reg;
    logic [7:0] bit_cnt_reg;
    logic [srf_pkg::FRAME_BITS-1:0] tx_sh_reg;
    logic [srf_pkg::FRAME_BITS-1:0] rx_sh_reg;
    logic sclk_rise;
    logic sclk_fall;
    logic sel_fall;
    logic sel_rise;

    ////////////////////////////////////////////////////////////////////////////
    // Edge detection; one-cycle phases suffice at the top serial rate
    assign sclk_rise = !sclk_q_reg && spi_sclk;
    assign sclk_fall = sclk_q_reg && !spi_sclk;
    assign sel_fall = nss_q_reg && !spi_nss_n;
    assign sel_rise = !nss_q_reg && spi_nss_n;

    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            sclk_q_reg <= 1'b0;
            nss_q_reg <= 1'b1;
        end
        else
        begin
            sclk_q_reg <= spi_sclk;
            nss_q_reg <= spi_nss_n;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Receive: sample on falling edge, MSB first, count bits
    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            bit_cnt_reg <= 8'h00;
            rx_sh_reg <= '0;
        end
        else if (sel_fall)
        begin
            bit_cnt_reg <= 8'h00;
        end
        else if (!spi_nss_n && sclk_fall)
        begin
            rx_sh_reg <= {rx_sh_reg[srf_pkg::FRAME_BITS-2:0], spi_mosi};
            if (bit_cnt_reg != srf_pkg::BIT_CNT_MAX)
            begin
                bit_cnt_reg <= bit_cnt_reg + 8'h01;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Transmit: answer frozen at select fall, launched on each rising edge
    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            tx_sh_reg <= '0;
            spi_miso <= 1'b0;
            spi_miso_oe <= 1'b0;
        end
        else
        begin
            spi_miso_oe <= !spi_nss_n; // Drive only while selected
            if (sel_fall)
            begin
                tx_sh_reg <= link.tx_frame;
                spi_miso <= 1'b0;
            end
            else if (!spi_nss_n && sclk_rise)
            begin
                spi_miso <= tx_sh_reg[srf_pkg::FRAME_BITS-1];
                tx_sh_reg <= {tx_sh_reg[srf_pkg::FRAME_BITS-2:0], 1'b0};
            end
            else if (spi_nss_n)
            begin
                spi_miso <= 1'b0;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Frame events; a frame counts only with exactly fourteen bytes
    always_ff @(posedge ref_clk)
    begin
        if (!rstn)
        begin
            link.frame_start <= 1'b0;
            link.frame_end <= 1'b0;
            link.frame_ok <= 1'b0;
            link.rx_frame <= '0;
        end
        else
        begin
            link.frame_start <= sel_fall;
            link.frame_end <= sel_rise;
            link.frame_ok <= sel_rise && (bit_cnt_reg == srf_pkg::FRAME_BITS_CNT);
            if (sel_rise)
            begin
                link.rx_frame <= rx_sh_reg;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Checks
    property p_msb_launch;
        @(posedge ref_clk) disable iff (!rstn)
        (!spi_nss_n && sclk_rise && !sel_fall) |=> spi_miso == $past(tx_sh_reg[111]);
    endproperty
    a_msb_launch: assert property (p_msb_launch) else $error("miso not MSB first");

    property p_frame_len;
        @(posedge ref_clk) disable iff (!rstn)
        link.frame_ok |-> link.frame_end && $past(bit_cnt_reg) == 8'h70;
    endproperty
    a_frame_len: assert property (p_frame_len) else $error("frame accepted, wrong length");

    property p_start_edge;
        @(posedge ref_clk) disable iff (!rstn)
        link.frame_start |-> $past(nss_q_reg) && !$past(spi_nss_n);
    endproperty
    a_start_edge: assert property (p_start_edge) else $error("start without select fall");
endmodule // srf_shift

// *** verification/srf_port_tb.sv ***
// Self-checking bench of the frame port; the bench plays the serial master.
// Assumes the store model behind the port; serial clock near 1.67 MHz.
module srf_port_tb;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic [31:0] FP = srf_pkg::FAIL_PATTERN;
    localparam logic [31:0] V1 = 32'h3D4CCCCD;
    localparam logic [31:0] V2 = 32'hBDA3D70A;
    localparam logic [31:0] V3 = 32'h40A00000;
    logic ref_clk, rstn, spi_sclk, spi_nss_n, spi_mosi;
    logic spi_miso, spi_miso_oe, frame_pending_flag;
    logic reg_req, reg_we, reg_ack, reg_fail;
    logic [15:0] reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    logic [111:0] rx;
    int err_count = 0;
    int n_checks = 0;
    //////////////////////////////////////////////////////////////////////////
    srf_port dut (.ref_clk(ref_clk), .rstn(rstn), .spi_sclk(spi_sclk),
        .spi_nss_n(spi_nss_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso),
        .spi_miso_oe(spi_miso_oe), .frame_pending_flag(frame_pending_flag),
        .reg_req(reg_req), .reg_we(reg_we), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_ack(reg_ack), .reg_fail(reg_fail), .reg_rdata(reg_rdata));
    srf_store_model store (.ref_clk(ref_clk), .reg_req(reg_req), .reg_we(reg_we),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_ack(reg_ack),
        .reg_fail(reg_fail), .reg_rdata(reg_rdata));
    //////////////////////////////////////////////////////////////////////////
    initial
    begin
        ref_clk = 1'b0;
        forever #50 ref_clk = ~ref_clk;
    end
    task automatic check(input logic [111:0] seen, input logic [111:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            err_count++;
            $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        if (err_count == 0 && n_checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // Inputs always move 10 ns after a rising edge
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #10;
    endtask
    function automatic logic [111:0] fr(input logic [15:0] w0, w1, w2,
        input logic [31:0] d1, d2);
        return {w0, w1, w2, d1, d2};
    endfunction
    // One frame; sclk phases of 3 cycles keep well inside the rate limit
    task automatic frame(input logic [111:0] tx, input int nbits);
        int i;
        tick(1);
        spi_nss_n = 1'b0;
        tick(3);
        check(112'(frame_pending_flag), 112'(1'b1));
        check(112'(spi_miso_oe), 112'(1'b1));
        for (i = 0; i < nbits; i++)
        begin
            spi_sclk = 1'b1;
            spi_mosi = tx[111-i];
            tick(3);
            rx[111-i] = spi_miso;
            spi_sclk = 1'b0;
            tick(3);
        end
        spi_nss_n = 1'b1;
        spi_mosi = ~spi_mosi;
        for (i = 0; i < 3000 && frame_pending_flag !== 1'b0; i++)
            tick(1);
        if (i == 3000)
        begin
            err_count++;
            summarize();
        end
        check(112'(spi_miso_oe), 112'(1'b0));
    endtask
    //////////////////////////////////////////////////////////////////////////
    // Each answer shows up during the following frame
    initial
    begin
        rstn = 1'b0;
        spi_sclk = 1'b0;
        spi_nss_n = 1'b1;
        spi_mosi = 1'b0;
        tick(20);
        check(112'({spi_miso_oe, frame_pending_flag, reg_req}), 112'(3'b000));
        rstn = 1'b1;
        frame(fr(16'h0001, 16'h5001, 16'h5101, V1, V2), 112);
        check(rx, fr(16'h0000, FP[31:16], FP[15:0], FP, FP));
        frame(fr(16'h0000, 16'h1234, 16'h0000, 32'h0, 32'h0), 112);
        check(rx, fr(16'h0001, 16'h5001, 16'h5101, V1, V2));
        frame(fr(16'h0001, 16'hE000, 16'h1234, 32'h0, V3), 112);
        check(rx, fr(16'h0000, 16'hA5A5, 16'h0000, V1, V2));
        frame(fr(16'h0000, 16'hE001, 16'h0000, 32'h0, 32'h0), 112);
        check(rx, fr(16'h0001, 16'h0000, 16'h1234, V1, V2));
        frame(fr(16'h0000, 16'h1234, 16'h0000, 32'h0, 32'h0), 100);
        frame(fr(16'h0000, 16'h1234, 16'h0000, 32'h0, 32'h0), 112);
        check(rx, fr(16'h0000, V3[31:16], V3[15:0], V1, V2));
        frame(fr(16'h0000, 16'h0000, 16'h0000, 32'h0, 32'h0), 112);
        check(rx, fr(16'h0000, FP[31:16], FP[15:0], V1, V2));
        // Move both pointers; the second one names an address that never answers
        frame(fr(16'h0001, 16'h0F00, 16'h0F01, 32'h00001234, 32'h0000D002), 112);
        check(rx, fr(16'h0000, V3[31:16], V3[15:0], V1, V2));
        frame(fr(16'h0000, 16'h5001, 16'h0000, 32'h0, 32'h0), 112);
        check(rx, fr(16'h0001, 16'h0F00, 16'h0F01, V3, FP));
        // Reset in mid-run brings back the power-up answer and pointer targets
        rstn = 1'b0;
        tick(2);
        rstn = 1'b1;
        frame(fr(16'h0000, 16'h5001, 16'h0000, 32'h0, 32'h0), 112);
        check(rx, fr(16'h0000, FP[31:16], FP[15:0], FP, FP));
        frame(fr(16'h0000, 16'h0000, 16'h0000, 32'h0, 32'h0), 112);
        check(rx, fr(16'h0000, 16'hA5A5, 16'h0000, V1, V2));
        summarize();
    end
endmodule // srf_port_tb

// *** verification/srf_store_model.sv ***
// Register store model answering the port's access requests.
// Assumes requests sampled on ref_clk; any address 0xExxx fails, 0xDxxx never answers.
module srf_store_model (
    // Clock
    input wire logic ref_clk,
    // Access
    input wire logic reg_req,
    input wire logic reg_we,
    input wire logic [15:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    output logic reg_ack,
    output logic reg_fail,
    output logic [31:0] reg_rdata
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [31:0] mem [logic [15:0]];
    logic slow;
    int cnt;
    //////////////////////////////////////////////////////////////////////////
    // Alternates prompt and slow answers; data scrambled outside the ack cycle
    initial
    begin
        reg_ack = 1'b0;
        reg_fail = 1'b0;
        reg_rdata = 32'h0;
        slow = 1'b0;
        cnt = 0;
        forever
        begin
            @(posedge ref_clk);
            #10;
            if (reg_req && !reg_ack && cnt < (slow ? 2 : 0))
            begin
                cnt++;
                reg_rdata = ~reg_rdata;
            end
            else if (reg_req && !reg_ack && reg_addr[15:12] != 4'hD)
            begin
                reg_ack = 1'b1;
                reg_fail = (reg_addr[15:12] == 4'hE);
                reg_rdata = mem.exists(reg_addr) ? mem[reg_addr] : {16'hA5A5, reg_addr};
                if (reg_we && !reg_fail)
                    mem[reg_addr] = reg_wdata;
                slow = !slow;
                cnt = 0;
            end
            else
            begin
                reg_ack = 1'b0;
                reg_rdata = ~reg_rdata;
            end
        end
    end
endmodule // srf_store_model
